// ### shared/lpdvt_pkg.sv
package lpdvt_pkg;

  // clocking
  localparam int HCLK_HZ         = 40_000_000;
  localparam int LINK_HALF_CYC   = 4;

  // line and frame geometry, in pixel clocks and lines
  localparam int LINE_ACTIVE     = 800;
  localparam int LINE_BLANK_MIN  = 160;
  localparam int LINE_BLANK_MAX  = 260;
  localparam int LINE_BLANK_TYP  = 256;
  localparam int FRAME_ACTIVE    = 600;
  localparam int FRAME_BLANK_MIN = 10;
  localparam int FRAME_BLANK_MAX = 192;
  localparam int FRAME_BLANK_TYP = 28;
  localparam int FRAME_RUN_MIN   = FRAME_BLANK_MIN * (LINE_ACTIVE + LINE_BLANK_MIN)
                                   + LINE_BLANK_MIN;
  localparam int FRAME_RUN_MAX   = FRAME_BLANK_MAX * (LINE_ACTIVE + LINE_BLANK_MAX)
                                   + LINE_BLANK_MAX;

  // spread modulation limits; the host divider applies none
  localparam int SSC_DEV_KHZ      = 1500;
  localparam int SSC_RATE_MIN_KHZ = 25;
  localparam int SSC_RATE_MAX_KHZ = 90;

  // supply sequencing
  localparam int POWER_OFF_TO_ON_GAP_MS = 500;
  localparam int POWER_GAP_CYC          = POWER_OFF_TO_ON_GAP_MS * (HCLK_HZ / 1000);
  localparam int SUPPLY_SETTLE_US       = 1000;
  localparam int SUPPLY_SETTLE_CYC      = SUPPLY_SETTLE_US * (HCLK_HZ / 1_000_000);
  localparam int BACKLIGHT_LEAD_US      = 1000;
  localparam int BACKLIGHT_LEAD_CYC     = BACKLIGHT_LEAD_US * (HCLK_HZ / 1_000_000);

  // widths
  localparam int COL_W  = 11;
  localparam int ROW_W  = 10;
  localparam int RUN_W  = 18;
  localparam int CHAN_W = 8;
  localparam int LOW_W  = 6;

  // register map
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_LINE_BLANK  = 8'h04;
  localparam logic [7:0] REG_FRAME_BLANK = 8'h08;
  localparam logic [7:0] REG_COLOUR      = 8'h0C;
  localparam logic [7:0] REG_STATUS      = 8'h10;

  localparam int CTRL_POWER_BIT     = 0;
  localparam int CTRL_DEPTH8_BIT    = 1;
  localparam int CTRL_REVERSE_BIT   = 2;
  localparam int CTRL_BACKLIGHT_BIT = 3;
  localparam logic [3:0]  CTRL_RESET   = 4'h2;
  localparam logic [23:0] COLOUR_RESET = 24'hFFFFFF;
  localparam int RED_LSB   = 16;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB  = 0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {PS_OFF, PS_SETTLE, PS_VIDEO, PS_BL_OFF, PS_GAP} lpdvt_pstate_t;

endpackage

// ### shared/lpdvt_link_if.sv
`timescale 1ns/1ps
interface lpdvt_link_if;
  logic       lvds_clock_pos;
  logic       lvds_clock_neg;
  logic       pixel_valid_strobe;
  logic       line_sync_in;
  logic       frame_sync_in;
  logic [7:0] red;
  logic [7:0] green;
  logic [7:0] blue;
  logic       colour_depth_select;
  logic       scan_reverse_select;
  logic       panel_supply_on;
  logic       backlight_on;

  modport host_end (
    output lvds_clock_pos, lvds_clock_neg, pixel_valid_strobe, line_sync_in,
           frame_sync_in, red, green, blue, colour_depth_select,
           scan_reverse_select, panel_supply_on, backlight_on
  );

  modport panel_end (
    input lvds_clock_pos, lvds_clock_neg, pixel_valid_strobe, line_sync_in,
          frame_sync_in, red, green, blue, colour_depth_select,
          scan_reverse_select, panel_supply_on, backlight_on
  );
endinterface

// ### src/lpdvt_sync.sv
`timescale 1ns/1ps
module lpdvt_sync #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lpdvt_sync_st_t;

  lpdvt_sync_st_t r_ff;
  lpdvt_sync_st_t nxt_r;

  always_comb begin
    nxt_r    = r_ff;
    nxt_r.s1 = d;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.s2;

endmodule

// ### src/lpdvt_panel.sv
`timescale 1ns/1ps
module lpdvt_panel
  import lpdvt_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // link from the host
  lpdvt_link_if.panel_end  link,
  // recovered pixels
  output logic             pix_valid,
  output logic [7:0]       pix_red,
  output logic [7:0]       pix_green,
  output logic [7:0]       pix_blue,
  output logic [9:0]       pix_col,
  output logic [9:0]       pix_row,
  output logic             frame_start,
  // timing checks
  output logic             sync_fault,
  output logic             line_fault,
  output logic             frame_fault
);

  typedef struct packed {
    logic             started;
    logic             prev_clk;
    logic             prev_de;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [RUN_W-1:0] run;
    logic             pix_valid;
    logic [7:0]       red;
    logic [7:0]       green;
    logic [7:0]       blue;
    logic [9:0]       pcol;
    logic [9:0]       prow;
    logic             frame_start;
    logic             sync_fault;
    logic             line_fault;
    logic             frame_fault;
  } lpdvt_panel_st_t;

  lpdvt_panel_st_t r_ff;
  lpdvt_panel_st_t nxt_r;
  logic [31:0]     raw;
  logic [31:0]     s;
  logic            s_clk;
  logic            s_de;
  logic            s_hs;
  logic            s_vs;
  logic            s_d8;
  logic            s_rev;
  logic            s_sup;
  logic [7:0]      s_r;
  logic [7:0]      s_g;
  logic [7:0]      s_b;

  assign raw = {link.lvds_clock_pos, link.lvds_clock_neg, link.pixel_valid_strobe,
                link.line_sync_in, link.frame_sync_in, link.colour_depth_select,
                link.scan_reverse_select, link.panel_supply_on,
                link.red, link.green, link.blue};

  lpdvt_sync #(.W(32)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (raw),
    .q     (s)
  );

  assign s_clk = s[31] & ~s[30];
  assign s_de  = s[29];
  assign s_hs  = s[28];
  assign s_vs  = s[27];
  assign s_d8  = s[26];
  assign s_rev = s[25];
  assign s_sup = s[24];
  assign s_r   = s[23:16];
  assign s_g   = s[15:8];
  assign s_b   = s[7:0];

  // 6-bit data sits in the low lines; top two bits replicated into the gap
  function automatic logic [7:0] expand(input logic [7:0] v, input logic d8);
    expand = d8 ? v : {v[LOW_W-1:0], v[LOW_W-1:LOW_W-2]};
  endfunction

  always_comb begin
    logic [COL_W-1:0] cidx;
    logic [ROW_W-1:0] ridx;
    cidx              = r_ff.col;
    ridx              = r_ff.row;
    nxt_r             = r_ff;
    nxt_r.pix_valid   = 1'b0;
    nxt_r.frame_start = 1'b0;
    if (!s_sup) begin
      // unpowered link carries nothing; restart tracking on next power-up
      nxt_r.started  = 1'b0;
      nxt_r.prev_clk = 1'b0;
      nxt_r.prev_de  = 1'b0;
      nxt_r.run      = '0;
    end else begin
      if (s_hs || s_vs) begin
        nxt_r.sync_fault = 1'b1;
      end
      nxt_r.prev_clk = s_clk;
      if (s_clk && !r_ff.prev_clk) begin
        nxt_r.prev_de = s_de;
        if (s_de) begin
          if (!r_ff.prev_de) begin
            cidx = '0;
            if (!r_ff.started) begin
              nxt_r.started     = 1'b1;
              ridx              = '0;
              nxt_r.frame_start = 1'b1;
            end else if (r_ff.run < RUN_W'(LINE_BLANK_MIN)) begin
              nxt_r.line_fault = 1'b1;
            end else if (r_ff.run > RUN_W'(LINE_BLANK_MAX)) begin
              if (r_ff.run < RUN_W'(FRAME_RUN_MIN) || r_ff.run > RUN_W'(FRAME_RUN_MAX)
                  || r_ff.row != ROW_W'(FRAME_ACTIVE)) begin
                nxt_r.frame_fault = 1'b1;
              end
              ridx              = '0;
              nxt_r.frame_start = 1'b1;
            end
          end
          nxt_r.row = ridx;
          if (cidx < COL_W'(LINE_ACTIVE) && ridx < ROW_W'(FRAME_ACTIVE)) begin
            nxt_r.pix_valid = 1'b1;
            nxt_r.red       = expand(s_r, s_d8);
            nxt_r.green     = expand(s_g, s_d8);
            nxt_r.blue      = expand(s_b, s_d8);
            nxt_r.pcol = s_rev ? 10'(LINE_ACTIVE - 1) - 10'(cidx) : 10'(cidx);
            nxt_r.prow = s_rev ? 10'(FRAME_ACTIVE - 1) - ridx : ridx;
          end else begin
            nxt_r.line_fault = 1'b1;
          end
          if (cidx != '1) begin
            nxt_r.col = cidx + 11'h1;
          end
        end else if (r_ff.prev_de) begin
          if (r_ff.col != COL_W'(LINE_ACTIVE)) begin
            nxt_r.line_fault = 1'b1;
          end
          if (r_ff.row != '1) begin
            nxt_r.row = r_ff.row + 10'h1;
          end
          nxt_r.run = 18'h1;
        end else if (r_ff.run != '1) begin
          nxt_r.run = r_ff.run + 18'h1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pix_valid   = r_ff.pix_valid;
  assign pix_red     = r_ff.red;
  assign pix_green   = r_ff.green;
  assign pix_blue    = r_ff.blue;
  assign pix_col     = r_ff.pcol;
  assign pix_row     = r_ff.prow;
  assign frame_start = r_ff.frame_start;
  assign sync_fault  = r_ff.sync_fault;
  assign line_fault  = r_ff.line_fault;
  assign frame_fault = r_ff.frame_fault;

endmodule

// ### src/lpdvt_host.sv
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - host holds line and frame sync low
// - 800 active clocks then 160-260 blank
// - 600 active lines then 10-192 blank
// - pixel clock spread within set limits; the host divider applies none
// - depth select picks 6 or 8-bit packing
// - 8-bit mode: one byte per colour
// - bit 7 is msb, bit 0 lsb
// - reverse select high flips scan direction
// - supply off: all inputs held low
// - supply on: every line actively driven
// - wait 500 ms before reapplying supply
// - backlight on only while panel operates
// - larger value gives brighter output
module lpdvt_host
  import lpdvt_pkg::*;
#(
  parameter int unsigned GAP_CYC    = POWER_GAP_CYC,
  parameter int unsigned SETTLE_CYC = SUPPLY_SETTLE_CYC,
  parameter int unsigned LEAD_CYC   = BACKLIGHT_LEAD_CYC,
  parameter int unsigned HALF_CYC   = LINK_HALF_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // link to the panel
  lpdvt_link_if.host_end   link
);

  typedef struct packed {
    lpdvt_pstate_t    ps;
    logic [31:0]      wait_cnt;
    logic [7:0]       div_cnt;
    logic             link_clk;
    logic             link_clk_n;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic             de;
    logic [23:0]      rgb;
    logic             supply;
    logic             backlight;
    logic             depth_pin;
    logic             rev_pin;
    logic [3:0]       ctrl;
    logic [8:0]       line_blank;
    logic [7:0]       frame_blank;
    logic [23:0]      colour;
    logic [15:0]      frame_cnt;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
  } lpdvt_host_st_t;

  lpdvt_host_st_t r_ff;
  lpdvt_host_st_t nxt_r;

  localparam lpdvt_host_st_t RESET_ST = '{
    ps:          PS_OFF,
    ctrl:        CTRL_RESET,
    line_blank:  9'(LINE_BLANK_TYP),
    frame_blank: 8'(FRAME_BLANK_TYP),
    colour:      COLOUR_RESET,
    default:     '0
  };

  // 6-bit mode carries the top six bits on the low six lines
  function automatic logic [7:0] pack_chan(input logic [7:0] v, input logic d8);
    pack_chan = d8 ? v : {2'h0, v[7:8-LOW_W]};
  endfunction

  function automatic logic [23:0] pack_pixel(input logic [23:0] c, input logic d8);
    pack_pixel = {pack_chan(c[RED_LSB+:CHAN_W], d8),
                  pack_chan(c[GREEN_LSB+:CHAN_W], d8),
                  pack_chan(c[BLUE_LSB+:CHAN_W], d8)};
  endfunction

  always_comb begin
    logic [8:0]       lb;
    logic [7:0]       fb;
    logic [COL_W-1:0] col_n;
    logic [ROW_W-1:0] row_n;
    logic             run;
    lb    = hwdata[8:0];
    fb    = hwdata[7:0];
    col_n = r_ff.col;
    row_n = r_ff.row;
    run   = 1'b0;
    nxt_r = r_ff;

    // data phase of a write lands first, so a following read sees it
    nxt_r.wr_pend = 1'b0;
    if (r_ff.wr_pend) begin
      case (r_ff.wr_addr)
        REG_CTRL: begin
          nxt_r.ctrl = hwdata[3:0];
        end
        REG_LINE_BLANK: begin
          if (lb < 9'(LINE_BLANK_MIN)) begin
            nxt_r.line_blank = 9'(LINE_BLANK_MIN);
          end else if (lb > 9'(LINE_BLANK_MAX)) begin
            nxt_r.line_blank = 9'(LINE_BLANK_MAX);
          end else begin
            nxt_r.line_blank = lb;
          end
        end
        REG_FRAME_BLANK: begin
          if (fb < 8'(FRAME_BLANK_MIN)) begin
            nxt_r.frame_blank = 8'(FRAME_BLANK_MIN);
          end else if (fb > 8'(FRAME_BLANK_MAX)) begin
            nxt_r.frame_blank = 8'(FRAME_BLANK_MAX);
          end else begin
            nxt_r.frame_blank = fb;
          end
        end
        REG_COLOUR: begin
          nxt_r.colour = hwdata[23:0];
        end
        default: begin
        end
      endcase
    end

    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      nxt_r.wr_pend = hwrite;
      nxt_r.wr_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          REG_CTRL:        nxt_r.rdata = {28'h0, nxt_r.ctrl};
          REG_LINE_BLANK:  nxt_r.rdata = {23'h0, nxt_r.line_blank};
          REG_FRAME_BLANK: nxt_r.rdata = {24'h0, nxt_r.frame_blank};
          REG_COLOUR:      nxt_r.rdata = {8'h0, nxt_r.colour};
          REG_STATUS:      nxt_r.rdata = {r_ff.frame_cnt, 13'h0, r_ff.ps};
          default:         nxt_r.rdata = 32'h0;
        endcase
      end
    end

    // supply sequencing
    nxt_r.wait_cnt = r_ff.wait_cnt + 32'h1;
    case (r_ff.ps)
      PS_OFF: begin
        if (r_ff.ctrl[CTRL_POWER_BIT]) begin
          nxt_r.ps         = PS_SETTLE;
          nxt_r.supply     = 1'b1;
          nxt_r.link_clk_n = 1'b1;
          nxt_r.wait_cnt   = '0;
        end
      end
      PS_SETTLE: begin
        if (r_ff.wait_cnt >= 32'(SETTLE_CYC - 1)) begin
          // first pixel is presented before the first rising edge
          nxt_r.ps         = PS_VIDEO;
          nxt_r.div_cnt    = '0;
          nxt_r.link_clk   = 1'b0;
          nxt_r.link_clk_n = 1'b1;
          nxt_r.col        = '0;
          nxt_r.row        = '0;
          nxt_r.de         = 1'b1;
          nxt_r.rgb        = pack_pixel(r_ff.colour, r_ff.ctrl[CTRL_DEPTH8_BIT]);
        end
      end
      PS_VIDEO: begin
        if (!r_ff.ctrl[CTRL_POWER_BIT]) begin
          nxt_r.ps       = PS_BL_OFF;
          nxt_r.wait_cnt = '0;
        end
      end
      PS_BL_OFF: begin
        // backlight already dark; video keeps running for the lead time
        if (r_ff.wait_cnt >= 32'(LEAD_CYC - 1)) begin
          nxt_r.ps         = PS_GAP;
          nxt_r.wait_cnt   = '0;
          nxt_r.supply     = 1'b0;
          nxt_r.link_clk   = 1'b0;
          nxt_r.link_clk_n = 1'b0;
          nxt_r.de         = 1'b0;
          nxt_r.rgb        = '0;
        end
      end
      PS_GAP: begin
        if (r_ff.wait_cnt >= 32'(GAP_CYC - 1)) begin
          nxt_r.ps = PS_OFF;
        end
      end
      default: begin
        nxt_r.ps = PS_OFF;
      end
    endcase

    // fixed divider: steady clock, no spread modulation
    // halted in the supply-off cycle so no edge or pixel escapes into the gap
    run = ((r_ff.ps == PS_VIDEO) || (r_ff.ps == PS_BL_OFF)) && nxt_r.supply;
    if (run) begin
      if (r_ff.div_cnt >= 8'(HALF_CYC - 1)) begin
        nxt_r.div_cnt    = '0;
        nxt_r.link_clk   = ~r_ff.link_clk;
        nxt_r.link_clk_n = r_ff.link_clk;
        if (r_ff.link_clk) begin
          // data changes on the falling edge, panel samples on the rising one
          col_n = r_ff.col + 11'h1;
          if (r_ff.col >= 11'(LINE_ACTIVE) + 11'(r_ff.line_blank) - 11'h1) begin
            col_n = '0;
            row_n = r_ff.row + 10'h1;
            if (r_ff.row >= 10'(FRAME_ACTIVE) + 10'(r_ff.frame_blank) - 10'h1) begin
              row_n           = '0;
              nxt_r.frame_cnt = r_ff.frame_cnt + 16'h1;
            end
          end
          nxt_r.col = col_n;
          nxt_r.row = row_n;
          nxt_r.de  = (col_n < COL_W'(LINE_ACTIVE)) && (row_n < ROW_W'(FRAME_ACTIVE));
          nxt_r.rgb = nxt_r.de ? pack_pixel(r_ff.colour, r_ff.ctrl[CTRL_DEPTH8_BIT])
                               : 24'h0;
        end
      end else begin
        nxt_r.div_cnt = r_ff.div_cnt + 8'h1;
      end
    end

    nxt_r.backlight = (nxt_r.ps == PS_VIDEO) && r_ff.ctrl[CTRL_BACKLIGHT_BIT];
    nxt_r.depth_pin = nxt_r.supply && r_ff.ctrl[CTRL_DEPTH8_BIT];
    nxt_r.rev_pin   = nxt_r.supply && r_ff.ctrl[CTRL_REVERSE_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff <= RESET_ST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r_ff.rdata;

  assign link.lvds_clock_pos      = r_ff.link_clk;
  assign link.lvds_clock_neg      = r_ff.link_clk_n;
  assign link.pixel_valid_strobe  = r_ff.de;
  assign link.line_sync_in        = 1'b0;
  assign link.frame_sync_in       = 1'b0;
  assign link.red                 = r_ff.rgb[RED_LSB+:CHAN_W];
  assign link.green               = r_ff.rgb[GREEN_LSB+:CHAN_W];
  assign link.blue                = r_ff.rgb[BLUE_LSB+:CHAN_W];
  assign link.colour_depth_select = r_ff.depth_pin;
  assign link.scan_reverse_select = r_ff.rev_pin;
  assign link.panel_supply_on     = r_ff.supply;
  assign link.backlight_on        = r_ff.backlight;

endmodule

// ### verification/lpdvt_link_assertions.sv
`timescale 1ns/1ps
module lpdvt_link_assertions (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // link
  input wire logic       lvds_clock_pos,
  input wire logic       lvds_clock_neg,
  input wire logic       pixel_valid_strobe,
  input wire logic       line_sync_in,
  input wire logic       frame_sync_in,
  input wire logic [7:0] red,
  input wire logic [7:0] green,
  input wire logic [7:0] blue,
  input wire logic       colour_depth_select,
  input wire logic       scan_reverse_select,
  input wire logic       panel_supply_on,
  input wire logic       backlight_on
);
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [9:0]  de_run_ff;
  logic [17:0] blank_run_ff;
  logic        line_seen_ff;
  logic [29:0] quiet_bits;

  assign quiet_bits = {lvds_clock_pos, lvds_clock_neg, pixel_valid_strobe, backlight_on,
                       colour_depth_select, scan_reverse_select, red, green, blue};

  // link clock rises counted within and between strobe runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      de_run_ff    <= 10'h000;
      blank_run_ff <= 18'h00000;
      line_seen_ff <= 1'b0;
    end else begin
      de_run_ff    <= !pixel_valid_strobe ? 10'h000 : de_run_ff + 10'($rose(lvds_clock_pos));
      blank_run_ff <= pixel_valid_strobe ? 18'h00000 : blank_run_ff + 18'($rose(lvds_clock_pos));
      line_seen_ff <= panel_supply_on && (line_seen_ff || $fell(pixel_valid_strobe));
    end
  end

  AST_SYNC_LOW: assert property (!line_sync_in && !frame_sync_in)
    else $error("sync input driven high");
  AST_OFF_QUIET: assert property (!panel_supply_on |-> quiet_bits == 30'h0)
    else $error("link active with supply off");
  AST_PAIR_DRIVEN: assert property (
    panel_supply_on && $past(panel_supply_on) |-> lvds_clock_neg == !lvds_clock_pos)
    else $error("clock pair not complementary");
  AST_BL_IN_VIDEO: assert property (
    backlight_on |-> panel_supply_on && $past(panel_supply_on))
    else $error("backlight on without panel running");
  AST_CLK_HALF: assert property (
    $rose(lvds_clock_pos) |-> (lvds_clock_pos || !panel_supply_on)[*4] and ##4 !lvds_clock_pos)
    else $error("link clock high phase wrong");
  AST_HOLD_HIGH: assert property (
    lvds_clock_pos |-> $stable({pixel_valid_strobe, red, green, blue}))
    else $error("data moved while clock high");
  AST_SIX_BIT_PAD: assert property (
    $rose(lvds_clock_pos) && pixel_valid_strobe && !colour_depth_select
    && !$past(colour_depth_select, 8) |-> {red[7:6], green[7:6], blue[7:6]} == 6'h00)
    else $error("upper lines set in 6-bit mode");
  AST_LINE_800: assert property (
    $fell(pixel_valid_strobe) && panel_supply_on |-> de_run_ff == 10'h320)
    else $error("active run not 800 clocks");
  AST_BLANK_RANGE: assert property (
    $rose(pixel_valid_strobe) && line_seen_ff |-> blank_run_ff >= 18'h000A0
    && (blank_run_ff <= 18'h00104 || blank_run_ff >= 18'h02620))
    else $error("blank run out of range");
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import lpdvt_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        pix_valid;
  logic [7:0]  pix_red;
  logic [7:0]  pix_green;
  logic [7:0]  pix_blue;
  logic [9:0]  pix_col;
  logic [9:0]  pix_row;
  logic        frame_start;
  logic        sync_fault;
  logic        line_fault;
  logic        frame_fault;
  logic [31:0] rd;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] rst_val [6] = '{32'h2, 32'h100, 32'h1C, 32'hFFFFFF, 32'h0, 32'h0};
  logic [7:0]  wr_addr [5] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h04};
  logic [31:0] wr_data [5] = '{32'h64, 32'h12C, 32'h5, 32'hC8, 32'hA0};
  logic [31:0] rd_exp  [5] = '{32'hA0, 32'h104, 32'hA, 32'hC0, 32'hA0};

  lpdvt_link_if link ();

  lpdvt_host #(.GAP_CYC(50), .SETTLE_CYC(20), .LEAD_CYC(20), .HALF_CYC(4)) lpdvt_host_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));

  lpdvt_panel lpdvt_panel_inst (
    .hclk(hclk), .hresetn(hresetn), .link(link), .pix_valid(pix_valid), .pix_red(pix_red),
    .pix_green(pix_green), .pix_blue(pix_blue), .pix_col(pix_col), .pix_row(pix_row),
    .frame_start(frame_start), .sync_fault(sync_fault), .line_fault(line_fault),
    .frame_fault(frame_fault));

  lpdvt_link_assertions lpdvt_link_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .lvds_clock_pos(link.lvds_clock_pos),
    .lvds_clock_neg(link.lvds_clock_neg), .pixel_valid_strobe(link.pixel_valid_strobe),
    .line_sync_in(link.line_sync_in), .frame_sync_in(link.frame_sync_in), .red(link.red),
    .green(link.green), .blue(link.blue), .colour_depth_select(link.colour_depth_select),
    .scan_reverse_select(link.scan_reverse_select), .panel_supply_on(link.panel_supply_on),
    .backlight_on(link.backlight_on));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single-word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_pix();
    do @(negedge hclk); while (pix_valid !== 1'b1);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk(rd, rst_val[i]);
    end
    // blank limits clamp to the legal range, ending on the shortest line
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, wr_addr[i], wr_data[i]);
      bus(1'b0, wr_addr[i], 32'h0);
      chk(rd, rd_exp[i]);
    end
    bus(1'b1, REG_COLOUR, 32'h8001FE);
    bus(1'b1, REG_CTRL, 32'h3);
    wait_pix();
    chk({12'h000, pix_col, pix_row}, 32'h0);
    chk({8'h00, pix_red, pix_green, pix_blue}, 32'h8001FE);
    chk({8'h00, link.red, link.green, link.blue}, 32'h8001FE);
    chk(32'(frame_start), 32'h1);
    repeat (799) wait_pix();
    chk({12'h000, pix_col, pix_row}, 32'hC7C00);
    wait_pix();
    chk({12'h000, pix_col, pix_row}, 32'h1);
    chk(32'(frame_start), 32'h0);
    @(posedge hclk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[2:0]), 32'h2);
    chk({29'h0, sync_fault, line_fault, frame_fault}, 32'h0);
    // switch to 6-bit packing in mid-line
    bus(1'b1, REG_COLOUR, 32'hFF8142);
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (4) wait_pix();
    chk({8'h00, pix_red, pix_green, pix_blue}, 32'hFF8241);
    chk({8'h00, link.red, link.green, link.blue}, 32'h3F2010);
    @(posedge hclk);
    bus(1'b1, REG_CTRL, 32'h0);
    do @(negedge hclk); while (link.panel_supply_on !== 1'b0);
    chk({5'h00, link.pixel_valid_strobe, link.lvds_clock_pos, link.backlight_on,
         link.red, link.green, link.blue}, 32'h0);
    // power requested again inside the off gap
    @(posedge hclk);
    bus(1'b1, REG_CTRL, 32'hF);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (link.panel_supply_on !== 1'b1);
    chk(32'(n >= 48), 32'h1);
    wait_pix();
    chk({12'h000, pix_col, pix_row}, 32'hC7E57);
    chk({8'h00, pix_red, pix_green, pix_blue}, 32'hFF8142);
    wait_pix();
    chk({12'h000, pix_col, pix_row}, 32'hC7A57);
    repeat (8) wait_pix();
    chk(32'(link.backlight_on), 32'h1);
    chk({29'h0, sync_fault, line_fault, frame_fault}, 32'h0);
    final_report();
  end
endmodule
